// [hdl/jle_cond_eval.v]
// Purpose: Evaluates the 4-bit condition field against the flags.
// Assumes: Flags arrive as carry, zero, sign, overflow.
// Notes:   Upper eight codes are the complements of the lower eight.
module jle_cond_eval (
    // Condition and flags
    input  wire [3:0] condition_field,
    input  wire       flag_c,
    input  wire       flag_z,
    input  wire       flag_s,
    input  wire       flag_v,
    // Result
    output reg        cond_true
);
    reg base;
    always @* begin
        base = 1'b0;
        case (condition_field[2:0])
            3'h0: base = 1'b0;
            3'h1: base = flag_s ^ flag_v;
            3'h2: base = flag_z | (flag_s ^ flag_v);
            3'h3: base = flag_c | flag_z;
            3'h4: base = flag_v;
            3'h5: base = flag_s;
            3'h6: base = flag_z;
            default: base = flag_c;
        endcase
        // Code 8 is the always-true form, as the complement of never.
        cond_true = condition_field[3] ? ~base : base;
    end
endmodule // jle_cond_eval

// [hdl/jle_exec.v]
// Purpose: Decode and execute jump, relative jump, load and program memory load.
// Assumes: Register file and program memory answer combinationally in the same cycle.
// Notes:   The PC presented at start points past the whole instruction; operand bytes arrive as inputs.
`include "jle_regs.vh"

module jle_exec (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        reset_n,
    // Instruction
    input  wire        start,
    input  wire [7:0]  opcode,
    input  wire [7:0]  operand1,
    input  wire [7:0]  operand2,
    input  wire [15:0] pc_in,
    input  wire [3:0]  wreg_group,
    // Flags in and out
    input  wire [7:0]  flags_in,
    output reg  [7:0]  flags_out,
    // Register file read ports
    output wire [7:0]  rf_raddr_a,
    input  wire [7:0]  rf_rdata_a,
    output wire [7:0]  rf_raddr_b,
    input  wire [7:0]  rf_rdata_b,
    // Register file write port
    output reg         rf_we,
    output reg  [7:0]  rf_waddr,
    output reg  [7:0]  rf_wdata,
    // Program memory
    output reg         pm_re,
    output reg         pm_we,
    output reg  [15:0] pm_addr,
    output reg  [7:0]  pm_wdata,
    input  wire [7:0]  pm_rdata,
    // Results
    output reg         pc_load,
    output reg  [15:0] pc_out,
    output reg  [7:0]  interrupt_enable_mask,
    output reg         busy,
    output reg         done,
    output reg  [7:0]  cycles,
    output reg         illegal
);
    localparam ST_IDLE = 2'd0;
    localparam ST_ADDR = 2'd1;
    localparam ST_WAIT = 2'd2;

    reg [1:0]  state;
    reg [1:0]  next_state;
    reg [7:0]  wait_cnt;
    reg [7:0]  next_wait_cnt;
    reg [7:0]  op_q;
    reg [7:0]  o1_q;
    reg [7:0]  o2_q;
    reg [15:0] pc_q;
    reg [7:0]  ptr_q;

    wire       cond_true;
    jle_cond_eval u_cond (
        .condition_field (op_q[7:4]),
        .flag_c          (flags_in[7]),
        .flag_z          (flags_in[6]),
        .flag_s          (flags_in[5]),
        .flag_v          (flags_in[4]),
        .cond_true       (cond_true)
    );

    // Working register address expansion.
    function [7:0] fa;
        input [7:0] b;
        begin
            if (b[7:4] == `JLE_WREG_PREFIX) begin
                fa = {wreg_group, b[3:0]};
            end else begin
                fa = b;
            end
        end
    endfunction

    function [7:0] wr;
        input [3:0] n;
        begin
            wr = {wreg_group, n};
        end
    endfunction

    wire [7:0] ind_pair = fa(o1_q);

    // Read port steering: phase 0 reads pointers/sources, phase 1 follows them.
    reg [7:0] ra_a;
    reg [7:0] ra_b;
    reg       two_phase;
    always @* begin
        ra_a = 8'h00;
        ra_b = 8'h00;
        two_phase = 1'b0;
        if (op_q == `JLE_OP_JP_IND) begin
            ra_a = {ind_pair[7:1], 1'b0};
            ra_b = {ind_pair[7:1], 1'b1};
        end else if (op_q == `JLE_OP_LD_R_IR) begin
            ra_a = wr(o1_q[3:0]);
            two_phase = 1'b1;
        end else if (op_q == `JLE_OP_LD_IR_R) begin
            ra_a = wr(o1_q[7:4]);
            ra_b = wr(o1_q[3:0]);
        end else if (op_q == `JLE_OP_LD_R_R || op_q == `JLE_OP_LD_IND_R) begin
            ra_a = fa(o1_q);
            ra_b = fa(o2_q);
        end else if (op_q == `JLE_OP_LD_R_IND) begin
            ra_a = fa(o1_q);
            two_phase = 1'b1;
        end else if (op_q == `JLE_OP_LD_IND_IM) begin
            ra_a = fa(o1_q);
        end else if (op_q == `JLE_OP_LD_X_FROM || op_q == `JLE_OP_LD_X_TO) begin
            ra_a = wr(o1_q[3:0]);
            ra_b = wr(o1_q[7:4]);
            two_phase = (op_q == `JLE_OP_LD_X_FROM);
        end else if (op_q == `JLE_OP_LDC_FROM || op_q == `JLE_OP_LDC_TO) begin
            ra_a = wr({o1_q[3:1], 1'b0});
            ra_b = wr({o1_q[3:1], 1'b1});
        end else if (op_q[3:0] == `JLE_STR_LOW_NIBBLE) begin
            ra_a = wr(op_q[7:4]);
        end else if (op_q[3:0] == `JLE_LDR_LOW_NIBBLE) begin
            ra_a = fa(o1_q);
        end
        // A fetched pointer is a full address, so it is not expanded as an operand byte.
        if (state == ST_WAIT && two_phase) begin
            ra_a = ptr_q;
        end else if (state == ST_WAIT && op_q == `JLE_OP_LDC_TO) begin
            ra_a = wr(o1_q[7:4]);
        end
    end
    assign rf_raddr_a = ra_a;
    assign rf_raddr_b = ra_b;

    wire [15:0] disp_ext = {{8{o1_q[7]}}, o1_q};
    // PC at start already points past the two-byte relative jump.
    wire [15:0] rel_target = pc_q + disp_ext;

    reg [7:0] cyc_sel;
    always @* begin
        cyc_sel = `JLE_CYC_LONG;
        if (opcode[3:0] == `JLE_RJ_LOW_NIBBLE || opcode[3:0] == `JLE_JP_LOW_NIBBLE) begin
            cyc_sel = `JLE_CYC_NOT_TAKEN;
        end else if (opcode == `JLE_OP_JP_IND) begin
            cyc_sel = `JLE_CYC_JP_IND;
        end else if (opcode == `JLE_OP_LDC_FROM || opcode == `JLE_OP_LDC_TO) begin
            cyc_sel = `JLE_CYC_LDC;
        end else if (opcode == `JLE_OP_LD_R_IR || opcode == `JLE_OP_LD_IR_R ||
                     opcode[3:0] == `JLE_LDI_LOW_NIBBLE || opcode[3:0] == `JLE_LDR_LOW_NIBBLE ||
                     opcode[3:0] == `JLE_STR_LOW_NIBBLE) begin
            cyc_sel = `JLE_CYC_SHORT;
        end
    end

    always @* begin
        next_state = state;
        next_wait_cnt = wait_cnt;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_ADDR;
                    next_wait_cnt = cyc_sel - 8'h02;
                end
            end
            ST_ADDR: begin
                next_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (wait_cnt == 8'h00) begin
                    next_state = ST_IDLE;
                end else begin
                    next_wait_cnt = wait_cnt - 8'h01;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            wait_cnt <= 8'h00;
            op_q <= 8'h00;
            o1_q <= 8'h00;
            o2_q <= 8'h00;
            pc_q <= 16'h0000;
            ptr_q <= 8'h00;
            flags_out <= 8'h00;
            rf_we <= 1'b0;
            rf_waddr <= 8'h00;
            rf_wdata <= 8'h00;
            pm_re <= 1'b0;
            pm_we <= 1'b0;
            pm_addr <= 16'h0000;
            pm_wdata <= 8'h00;
            pc_load <= 1'b0;
            pc_out <= 16'h0000;
            interrupt_enable_mask <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
            cycles <= 8'h00;
            illegal <= 1'b0;
        end else begin
            state <= next_state;
            wait_cnt <= next_wait_cnt;
            rf_we <= 1'b0;
            pm_re <= 1'b0;
            pm_we <= 1'b0;
            pc_load <= 1'b0;
            done <= 1'b0;
            flags_out <= flags_in;
            if (rf_we && rf_waddr == `JLE_IMASK_ADDR) begin
                interrupt_enable_mask <= rf_wdata;
            end
            if (state == ST_IDLE && start) begin
                op_q <= opcode;
                o1_q <= operand1;
                o2_q <= operand2;
                pc_q <= pc_in;
                busy <= 1'b1;
                cycles <= cyc_sel;
                illegal <= 1'b0;
            end
            if (state == ST_ADDR) begin
                ptr_q <= rf_rdata_a;
                if (op_q[3:0] == `JLE_RJ_LOW_NIBBLE) begin
                    if (cond_true) begin
                        pc_load <= 1'b1;
                        pc_out <= rel_target;
                        cycles <= `JLE_CYC_TAKEN;
                        wait_cnt <= next_wait_cnt + 8'h02;
                    end
                end else if (op_q[3:0] == `JLE_JP_LOW_NIBBLE) begin
                    if (cond_true) begin
                        pc_load <= 1'b1;
                        pc_out <= {o1_q, o2_q};
                        cycles <= `JLE_CYC_TAKEN;
                        wait_cnt <= next_wait_cnt + 8'h02;
                    end
                end else if (op_q == `JLE_OP_JP_IND) begin
                    pc_load <= 1'b1;
                    pc_out <= {rf_rdata_a, rf_rdata_b};
                end else if (op_q == `JLE_OP_LD_IR_R) begin
                    rf_we <= 1'b1;
                    rf_waddr <= rf_rdata_a;
                    rf_wdata <= rf_rdata_b;
                end else if (op_q == `JLE_OP_LD_R_R) begin
                    rf_we <= 1'b1;
                    rf_waddr <= fa(o2_q);
                    rf_wdata <= rf_rdata_a;
                end else if (op_q == `JLE_OP_LD_IND_R) begin
                    rf_we <= 1'b1;
                    rf_waddr <= rf_rdata_b;
                    rf_wdata <= rf_rdata_a;
                end else if (op_q == `JLE_OP_LD_R_IM) begin
                    rf_we <= 1'b1;
                    rf_waddr <= fa(o1_q);
                    rf_wdata <= o2_q;
                end else if (op_q == `JLE_OP_LD_IND_IM) begin
                    rf_we <= 1'b1;
                    rf_waddr <= rf_rdata_a;
                    rf_wdata <= o2_q;
                end else if (op_q == `JLE_OP_LD_X_FROM) begin
                    ptr_q <= o2_q + rf_rdata_a;
                end else if (op_q == `JLE_OP_LD_X_TO) begin
                    rf_we <= 1'b1;
                    rf_waddr <= o2_q + rf_rdata_a;
                    rf_wdata <= rf_rdata_b;
                end else if (op_q == `JLE_OP_LDC_FROM) begin
                    pm_re <= 1'b1;
                    pm_addr <= {rf_rdata_a, rf_rdata_b};
                end else if (op_q == `JLE_OP_LDC_TO) begin
                    // Both read ports hold the pair now; the data byte is read in the second phase.
                    pm_addr <= {rf_rdata_a, rf_rdata_b};
                end else if (op_q[3:0] == `JLE_LDI_LOW_NIBBLE) begin
                    rf_we <= 1'b1;
                    rf_waddr <= wr(op_q[7:4]);
                    rf_wdata <= o1_q;
                end else if (op_q[3:0] == `JLE_LDR_LOW_NIBBLE) begin
                    rf_we <= 1'b1;
                    rf_waddr <= wr(op_q[7:4]);
                    rf_wdata <= rf_rdata_a;
                end else if (op_q[3:0] == `JLE_STR_LOW_NIBBLE) begin
                    rf_we <= 1'b1;
                    rf_waddr <= fa(o1_q);
                    rf_wdata <= rf_rdata_a;
                end else if (op_q != `JLE_OP_LD_R_IR && op_q != `JLE_OP_LD_R_IND) begin
                    illegal <= 1'b1;
                end
            end
            // Second phase: follow a pointer, complete a program memory read or perform the program memory write.
            if (state == ST_WAIT && wait_cnt == cycles - 8'h03) begin
                if (op_q == `JLE_OP_LD_R_IR) begin
                    rf_we <= 1'b1;
                    rf_waddr <= wr(o1_q[7:4]);
                    rf_wdata <= rf_rdata_a;
                end else if (op_q == `JLE_OP_LD_R_IND) begin
                    rf_we <= 1'b1;
                    rf_waddr <= fa(o2_q);
                    rf_wdata <= rf_rdata_a;
                end else if (op_q == `JLE_OP_LD_X_FROM) begin
                    rf_we <= 1'b1;
                    rf_waddr <= wr(o1_q[7:4]);
                    rf_wdata <= rf_rdata_a;
                end else if (op_q == `JLE_OP_LDC_FROM) begin
                    rf_we <= 1'b1;
                    rf_waddr <= wr(o1_q[7:4]);
                    rf_wdata <= pm_rdata;
                end else if (op_q == `JLE_OP_LDC_TO) begin
                    pm_we <= 1'b1;
                    pm_wdata <= rf_rdata_a;
                end
            end
            if (state == ST_WAIT && wait_cnt == 8'h00) begin
                busy <= 1'b0;
                done <= 1'b1;
            end
        end
    end
endmodule // jle_exec

// [hdl/jle_regs.vh]
// Purpose: Constants for the jump and load execution unit.
// Assumes: 8-bit register file, 16-bit program counter.
// Notes:   Opcodes, addressing prefixes and cycle counts.
`ifndef JLE_REGS_VH
`define JLE_REGS_VH

`define JLE_WREG_PREFIX     4'he
`define JLE_IMASK_ADDR      8'hfb
`define JLE_RJ_LOW_NIBBLE   4'hb
`define JLE_JP_LOW_NIBBLE   4'hd
`define JLE_LDI_LOW_NIBBLE  4'hc
`define JLE_LDR_LOW_NIBBLE  4'h8
`define JLE_STR_LOW_NIBBLE  4'h9
`define JLE_OP_JP_IND       8'h30
`define JLE_OP_LD_R_IR      8'he3
`define JLE_OP_LD_IR_R      8'hf3
`define JLE_OP_LD_R_R       8'he4
`define JLE_OP_LD_R_IND     8'he5
`define JLE_OP_LD_R_IM      8'he6
`define JLE_OP_LD_IND_IM    8'he7
`define JLE_OP_LD_IND_R     8'hf5
`define JLE_OP_LD_X_FROM    8'hc7
`define JLE_OP_LD_X_TO      8'hd7
`define JLE_OP_LDC_FROM     8'hc2
`define JLE_OP_LDC_TO       8'hd2
`define JLE_CYC_SHORT       8'h06
`define JLE_CYC_JP_IND      8'h08
`define JLE_CYC_LONG        8'h0a
`define JLE_CYC_TAKEN       8'h0c
`define JLE_CYC_NOT_TAKEN   8'h0a
`define JLE_CYC_LDC         8'h0c

`endif

// [test/jle_exec_bench.sv]
// Purpose: Self-checking bench for the jump and load execution unit.
// Assumes: One instruction at a time; the next start follows done.
// Notes:   Inputs change on the falling edge only.
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin errors++; \
    $display("MISMATCH %s expected %0h seen %0h", n, e, a); end end
module jle_exec_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        start = 1'b0;
    logic [7:0]  opcode = 8'h00, operand1 = 8'h00, operand2 = 8'h00, flags_in = 8'h00;
    logic [15:0] pc_in = 16'h0000;
    logic [3:0]  wreg_group = 4'h0;
    wire  [7:0]  flags_out, rf_raddr_a, rf_rdata_a, rf_raddr_b, rf_rdata_b, rf_waddr, rf_wdata;
    wire  [7:0]  pm_wdata, pm_rdata, interrupt_enable_mask, cycles;
    wire  [15:0] pm_addr, pc_out;
    wire         rf_we, pm_re, pm_we, pc_load, busy, done, illegal;
    int          errors = 0, checked = 0;
    logic        saw_load;
    logic [15:0] new_pc;
    logic        exp_illegal = 1'b0;

    always #50 clk_sys = ~clk_sys;

    jle_exec u_jle_exec (.clk_sys(clk_sys), .reset_n(reset_n), .start(start), .opcode(opcode),
        .operand1(operand1), .operand2(operand2), .pc_in(pc_in), .wreg_group(wreg_group),
        .flags_in(flags_in), .flags_out(flags_out), .rf_raddr_a(rf_raddr_a), .rf_rdata_a(rf_rdata_a),
        .rf_raddr_b(rf_raddr_b), .rf_rdata_b(rf_rdata_b), .rf_we(rf_we), .rf_waddr(rf_waddr),
        .rf_wdata(rf_wdata), .pm_re(pm_re), .pm_we(pm_we), .pm_addr(pm_addr), .pm_wdata(pm_wdata),
        .pm_rdata(pm_rdata), .pc_load(pc_load), .pc_out(pc_out),
        .interrupt_enable_mask(interrupt_enable_mask), .busy(busy), .done(done), .cycles(cycles),
        .illegal(illegal));

    jle_mem_model u_jle_mem_model (.clk_sys(clk_sys), .rf_raddr_a(rf_raddr_a), .rf_rdata_a(rf_rdata_a),
        .rf_raddr_b(rf_raddr_b), .rf_rdata_b(rf_rdata_b), .rf_we(rf_we), .rf_waddr(rf_waddr),
        .rf_wdata(rf_wdata), .pm_re(pm_re), .pm_we(pm_we), .pm_addr(pm_addr), .pm_wdata(pm_wdata),
        .pm_rdata(pm_rdata));

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Runs one instruction; new_pc starts unknown so a jump that never loads cannot match.
    task automatic issue(input logic [7:0] op, o1, o2, input logic [15:0] pc, input logic [7:0] cyc);
        int n;
        @(negedge clk_sys);
        opcode = op; operand1 = o1; operand2 = o2; pc_in = pc; start = 1'b1;
        saw_load = 1'b0;
        new_pc = 16'hxxxx;
        for (n = 0; n < 40; n++) begin
            @(negedge clk_sys);
            start = 1'b0;
            if (pc_load === 1'b1) begin saw_load = 1'b1; new_pc = pc_out; end
            if (done === 1'b1) break;
        end
        `CHK("done", 1'b1, done)
        `CHK("cycles", cyc, cycles)
        `CHK("flags", flags_in, flags_out)
        `CHK("illegal", exp_illegal, illegal)
    endtask

    task automatic t_relative;
        flags_in = 8'h20;
        issue(8'h8b, 8'hd3, 8'h00, 16'h1000, 8'h0c); `CHK("pc", 16'h0fd3, new_pc)
        issue(8'h5b, 8'h7f, 8'h00, 16'h1000, 8'h0c); `CHK("pc", 16'h107f, new_pc)
        issue(8'hdb, 8'h80, 8'h00, 16'h1000, 8'h0a); `CHK("load", 1'b0, saw_load)
        flags_in = 8'h00;
        issue(8'hdb, 8'h80, 8'h00, 16'h1000, 8'h0c); `CHK("pc", 16'h0f80, new_pc)
        issue(8'h0b, 8'h10, 8'h00, 16'h1000, 8'h0a); `CHK("load", 1'b0, saw_load)
        $display("test relative_jump done");
    endtask

    task automatic t_absolute;
        flags_in = 8'h80;
        issue(8'h7d, 8'h15, 8'h20, 16'h2000, 8'h0c); `CHK("pc", 16'h1520, new_pc)
        flags_in = 8'h00;
        issue(8'h7d, 8'h15, 8'h20, 16'h2000, 8'h0a); `CHK("load", 1'b0, saw_load)
        issue(8'h8d, 8'hab, 8'hcd, 16'h2000, 8'h0c); `CHK("pc", 16'habcd, new_pc)
        wreg_group = 4'h1;
        u_jle_mem_model.rf[8'h12] = 8'h3f;
        u_jle_mem_model.rf[8'h13] = 8'h45;
        issue(8'h30, 8'he2, 8'h00, 16'h2000, 8'h08); `CHK("pc", 16'h3f45, new_pc)
        u_jle_mem_model.rf[8'h40] = 8'h12;
        u_jle_mem_model.rf[8'h41] = 8'h34;
        issue(8'h30, 8'h40, 8'h00, 16'h2000, 8'h08); `CHK("pc", 16'h1234, new_pc)
        $display("test absolute_jump done");
    endtask

    task automatic t_load;
        wreg_group = 4'h2;
        issue(8'hfc, 8'h34, 8'h00, 16'h0000, 8'h06); `CHK("r2f", 8'h34, u_jle_mem_model.rf[8'h2f])
        u_jle_mem_model.rf[8'h45] = 8'hcf;
        u_jle_mem_model.rf[8'hcf] = 8'hff;
        issue(8'he4, 8'h45, 8'h34, 16'h0000, 8'h0a); `CHK("r34", 8'hcf, u_jle_mem_model.rf[8'h34])
        `CHK("r45", 8'hcf, u_jle_mem_model.rf[8'h45])
        issue(8'he5, 8'h45, 8'h34, 16'h0000, 8'h0a); `CHK("r34", 8'hff, u_jle_mem_model.rf[8'h34])
        wreg_group = 4'h0;
        u_jle_mem_model.rf[8'h0e] = 8'h7f;
        issue(8'he7, 8'hee, 8'hfc, 16'h0000, 8'h0a); `CHK("r7f", 8'hfc, u_jle_mem_model.rf[8'h7f])
        u_jle_mem_model.rf[8'h00] = 8'h08;
        u_jle_mem_model.rf[8'h2c] = 8'h4f;
        issue(8'hc7, 8'ha0, 8'h24, 16'h0000, 8'h0a); `CHK("r0a", 8'h4f, u_jle_mem_model.rf[8'h0a])
        u_jle_mem_model.rf[8'h00] = 8'h0b;
        u_jle_mem_model.rf[8'h0a] = 8'h83;
        issue(8'hd7, 8'ha0, 8'hf0, 16'h0000, 8'h0a); `CHK("rfb", 8'h83, u_jle_mem_model.rf[8'hfb])
        `CHK("mask", 8'h83, interrupt_enable_mask)
        issue(8'hf8, 8'h34, 8'h00, 16'h0000, 8'h06); `CHK("r0f", 8'hff, u_jle_mem_model.rf[8'h0f])
        issue(8'he9, 8'h35, 8'h00, 16'h0000, 8'h06); `CHK("r35", 8'h7f, u_jle_mem_model.rf[8'h35])
        u_jle_mem_model.rf[8'h0c] = 8'h34;
        issue(8'he3, 8'hdc, 8'h00, 16'h0000, 8'h06); `CHK("r0d", 8'hff, u_jle_mem_model.rf[8'h0d])
        issue(8'hf3, 8'hec, 8'h00, 16'h0000, 8'h06); `CHK("r7f", 8'h34, u_jle_mem_model.rf[8'h7f])
        `CHK("r0e", 8'h7f, u_jle_mem_model.rf[8'h0e])
        issue(8'he6, 8'h36, 8'ha4, 16'h0000, 8'h0a); `CHK("r36", 8'ha4, u_jle_mem_model.rf[8'h36])
        issue(8'hf5, 8'h45, 8'h34, 16'h0000, 8'h0a); `CHK("rff", 8'hcf, u_jle_mem_model.rf[8'hff])
        exp_illegal = 1'b1;
        issue(8'h01, 8'h00, 8'h00, 16'h0000, 8'h0a); `CHK("load", 1'b0, saw_load)
        exp_illegal = 1'b0;
        $display("test register_load done");
    endtask

    task automatic t_program_load;
        u_jle_mem_model.rf[8'h06] = 8'h30;
        u_jle_mem_model.rf[8'h07] = 8'ha2;
        u_jle_mem_model.pm[16'h30a2] = 8'h22;
        issue(8'hc2, 8'h26, 8'h00, 16'h0000, 8'h0c); `CHK("r02", 8'h22, u_jle_mem_model.rf[8'h02])
        `CHK("pm30a2", 8'h22, u_jle_mem_model.pm[16'h30a2])
        u_jle_mem_model.rf[8'h06] = 8'h10;
        issue(8'hd2, 8'h26, 8'h00, 16'h0000, 8'h0c); `CHK("pm10a2", 8'h22, u_jle_mem_model.pm[16'h10a2])
        `CHK("r02", 8'h22, u_jle_mem_model.rf[8'h02])
        $display("test program_memory_load done");
    endtask

    initial begin
        repeat (5) @(negedge clk_sys);
        reset_n = 1'b1;
        `CHK("busy", 1'b0, busy)
        t_relative;
        t_absolute;
        t_load;
        t_program_load;
        end_sim;
    end

    // Twenty-five instructions of at most twelve cycles fit well inside this span.
    initial begin
        #(100 * 3000);
        errors++;
        $display("MISMATCH watchdog expected done seen timeout");
        end_sim;
    end
endmodule // jle_exec_bench

// [test/jle_exec_properties.sv]
// Purpose: Timing and decode properties of the jump and load execution unit.
// Assumes: An instruction is taken on an edge where start is high and busy low.
// Notes:   Bound to every jle_exec instance at the foot of this file.
module jle_exec_checker (
    // Clock and reset
    input logic        clk_sys,
    input logic        reset_n,
    // Instruction
    input logic        start,
    input logic [7:0]  opcode,
    input logic [7:0]  operand1,
    input logic [7:0]  operand2,
    input logic [15:0] pc_in,
    input logic [3:0]  wreg_group,
    // Flags
    input logic [7:0]  flags_in,
    input logic [7:0]  flags_out,
    // Writes and results
    input logic        rf_we,
    input logic [7:0]  rf_waddr,
    input logic [7:0]  rf_wdata,
    input logic        pm_we,
    input logic        pc_load,
    input logic [15:0] pc_out,
    input logic [7:0]  interrupt_enable_mask,
    input logic        busy,
    input logic        done,
    input logic [7:0]  cycles
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        take;
    logic [7:0]  op_q;
    logic [7:0]  imm_q;
    logic [3:0]  grp_q;
    logic [15:0] tgt_q;

    assign take = start && !busy;

    // The instruction is kept here because the inputs may change once it is taken.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            op_q  <= 8'h00;
            imm_q <= 8'h00;
            grp_q <= 4'h0;
            tgt_q <= 16'h0000;
        end else if (take) begin
            op_q  <= opcode;
            imm_q <= operand1;
            grp_q <= wreg_group;
            tgt_q <= (opcode[3:0] == 4'hd) ? {operand1, operand2} : pc_in + {{8{operand1[7]}}, operand1};
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    AST_FLAGS: assert property ($past(reset_n) |-> flags_out == $past(flags_in))
        else $error("flags changed by instruction");
    AST_JUMP_TAKEN: assert property (take && (opcode == 8'h8b || opcode == 8'h8d)
        |-> ##[1:3] (pc_load && pc_out == tgt_q)) else $error("taken jump target wrong");
    AST_JUMP_NEVER: assert property (take && opcode == 8'h0b |=> !pc_load [*8])
        else $error("never condition loaded pc");
    AST_RJ_CYCLES: assert property (done && op_q[3:0] == 4'hb && op_q[6:4] == 3'h0
        |-> cycles == (op_q[7] ? 8'h0c : 8'h0a)) else $error("relative jump cycles wrong");
    AST_SHORT_CYCLES: assert property (done && op_q[3:0] == 4'hc |-> cycles == 8'h06)
        else $error("short load cycles wrong");
    AST_LDC_CYCLES: assert property (done && (op_q == 8'hc2 || op_q == 8'hd2) |-> cycles == 8'h0c)
        else $error("program memory load cycles wrong");
    AST_IMM_WREG: assert property (rf_we && op_q[3:0] == 4'hc
        |-> rf_waddr == {grp_q, op_q[7:4]} && rf_wdata == imm_q) else $error("immediate load wrong");
    AST_IMASK: assert property (rf_we && rf_waddr == 8'hfb |=> interrupt_enable_mask == $past(rf_wdata))
        else $error("interrupt mask not updated");
    AST_PM_WE: assert property (pm_we |-> op_q == 8'hd2)
        else $error("program memory written by wrong instruction");

    cover property (take && opcode == 8'h8b);
    cover property (done && op_q == 8'hd7);
    cover property (pm_we);
endmodule // jle_exec_checker

bind jle_exec jle_exec_checker u_jle_exec_checker (
    .clk_sys(clk_sys), .reset_n(reset_n), .start(start), .opcode(opcode), .operand1(operand1),
    .operand2(operand2), .pc_in(pc_in), .wreg_group(wreg_group), .flags_in(flags_in),
    .flags_out(flags_out), .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .pm_we(pm_we),
    .pc_load(pc_load), .pc_out(pc_out), .interrupt_enable_mask(interrupt_enable_mask),
    .busy(busy), .done(done), .cycles(cycles));

// [test/jle_mem_model.sv]
// Purpose: Register file and program memory facing the execution unit.
// Assumes: Register reads are combinational; writes land on the rising edge.
// Notes:   Program memory data is only valid for a few cycles after a read strobe.
module jle_mem_model (
    // Clock
    input  logic        clk_sys,
    // Register file
    input  logic [7:0]  rf_raddr_a,
    output logic [7:0]  rf_rdata_a,
    input  logic [7:0]  rf_raddr_b,
    output logic [7:0]  rf_rdata_b,
    input  logic        rf_we,
    input  logic [7:0]  rf_waddr,
    input  logic [7:0]  rf_wdata,
    // Program memory
    input  logic        pm_re,
    input  logic        pm_we,
    input  logic [15:0] pm_addr,
    input  logic [7:0]  pm_wdata,
    output logic [7:0]  pm_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rf [256];
    logic [7:0] pm [65536];
    logic [2:0] open_cnt = 3'h0;
    logic [7:0] junk     = 8'h5a;

    assign rf_rdata_a = rf[rf_raddr_a];
    assign rf_rdata_b = rf[rf_raddr_b];
    // Junk that flips each cycle outside a read, so a sample taken too late cannot pass by luck.
    assign pm_rdata   = (pm_re || open_cnt != 3'h0) ? pm[pm_addr] : junk;

    always @(posedge clk_sys) begin
        if (rf_we) rf[rf_waddr] <= rf_wdata;
        if (pm_we) pm[pm_addr] <= pm_wdata;
        open_cnt <= pm_re ? 3'h3 : (open_cnt != 3'h0 ? open_cnt - 3'h1 : 3'h0);
        junk     <= ~junk;
    end
endmodule // jle_mem_model
